/* File: src/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;
  // ==================================================
  // Register map, byte addresses on a 32-bit bus
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOWER = 8'h04;
  localparam logic [7:0] OFS_ADDR_UPPER = 8'h08;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h0C;
  localparam logic [7:0] OFS_TABLE_PAGE = 8'h10;
  localparam logic [7:0] OFS_LATCH_INDEX = 8'h14;
  localparam logic [7:0] OFS_LATCH_DATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // ==================================================
  // Control register fields
  localparam int BIT_LAUNCH = 15;
  localparam int BIT_ALLOW = 14;
  localparam int BIT_FAULT = 13;
  localparam int BIT_IDLE_OFF = 12;
  localparam int OPSEL_LSB = 0;
  localparam int OPSEL_W = 4;

  // ==================================================
  // Reset values and keys
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] LATCH_PAGE = 8'hFA;

  // ==================================================
  // Operation codes and geometry
  localparam logic [3:0] OP_DWORD = 4'h1;
  localparam logic [3:0] OP_ROW = 4'h2;
  localparam logic [3:0] OP_PAGE = 4'h3;
  localparam logic [3:0] OP_UNUSED = 4'h4;
  localparam logic [3:0] OP_CHIP = 4'hE;
  localparam int ROW_WORDS = 128;
  localparam int PAGE_WORDS = 1024;
  localparam int DWORD_WORDS = 2;
  localparam int LATCH_IDX_W = 7;
  localparam int LATCH_W = 24;
  localparam logic [23:0] ROW_MASK = 24'hff_ff00;
  localparam logic [23:0] PAGE_MASK = 24'hff_f800;
  localparam logic [23:0] CHIP_BASE = 24'h00_0000;

  // ==================================================
  // Types
  typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_OPEN} unlock_t;

  typedef struct packed {
    logic [3:0] op;
    logic [23:0] addr;
    logic [23:0] data;
  } flash_cmd_t;
endpackage : flash_ctrl_pkg

/* File: src/flash_program_erase_ctrl.sv */
`timescale 1ns/1ps
module flash_program_erase_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [flash_ctrl_pkg::REG_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cpu_stall_o,
  input wire logic idle_i,
  output logic mem_power_off_o,
  output logic mem_standby_o,
  output logic flash_req_o,
  output flash_ctrl_pkg::flash_cmd_t flash_cmd_o,
  input wire logic flash_done_i
);
  import flash_ctrl_pkg::*;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_PROG} seq_state_t;

  logic ack;
  logic [31:0] rd_data;
  logic launch, allow, fault, idle_off;
  logic [OPSEL_W-1:0] op_select;
  logic [7:0] dest_upper;
  logic [15:0] dest_lower;
  logic [7:0] table_page;
  logic [LATCH_IDX_W-1:0] latch_idx;
  unlock_t unlock, next_unlock;
  seq_state_t seq, next_seq;
  logic [7:0] word;
  flash_cmd_t cmd;
  logic pwr_off, pwr_standby;
  logic [LATCH_W-1:0] latch_rdata;

  // ==================================================
  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack;
  // Write lands on the edge where the master sees ack, never before
  wire bus_done = wb_cyc_i & wb_stb_i & ack;
  // Writes are dropped while busy; the core is stalled then anyway
  wire bus_write = bus_done & wb_we_i & ~launch;
  wire hit_ctl = wb_adr_i == OFS_CONTROL;
  wire hit_lower = wb_adr_i == OFS_ADDR_LOWER;
  wire hit_upper = wb_adr_i == OFS_ADDR_UPPER;
  wire hit_key = wb_adr_i == OFS_UNLOCK_KEY;
  wire hit_page = wb_adr_i == OFS_TABLE_PAGE;
  wire hit_idx = wb_adr_i == OFS_LATCH_INDEX;
  wire hit_ldata = wb_adr_i == OFS_LATCH_DATA;
  wire hit_status = wb_adr_i == OFS_STATUS;
  wire key_wr = bus_write & hit_key & wb_sel_i[0];
  wire key_first = key_wr & (wb_dat_i[7:0] == KEY_FIRST);
  wire key_second = key_wr & (wb_dat_i[7:0] == KEY_SECOND);
  wire ctl_hi_we = bus_write & hit_ctl & wb_sel_i[1];
  wire ctl_lo_we = bus_write & hit_ctl & wb_sel_i[0];
  wire next_allow = ctl_hi_we ? wb_dat_i[BIT_ALLOW] : allow;
  wire [OPSEL_W-1:0] next_op = ctl_lo_we ? wb_dat_i[OPSEL_LSB +: OPSEL_W] : op_select;
  wire op_known = (next_op == OP_DWORD) | (next_op == OP_ROW) | (next_op == OP_PAGE) | (next_op == OP_CHIP);
  wire launch_try = ctl_hi_we & wb_dat_i[BIT_LAUNCH];
  wire launch_ok = launch_try & (unlock == KEY_OPEN) & next_allow & op_known;
  wire launch_bad = launch_try & ~launch_ok;
  wire abort = sys_rst_i & launch;
  wire latch_we = bus_write & hit_ldata & (table_page == LATCH_PAGE) & (|wb_sel_i[2:0]);

  // ==================================================
  // Unlock sequence
  always_comb begin
    next_unlock = unlock;
    if (bus_write) begin
      if (key_first) begin
        next_unlock = KEY_HALF;
      end else if (key_second && unlock == KEY_HALF) begin
        next_unlock = KEY_OPEN;
      end else begin
        // Any other write spends or cancels the unlock
        next_unlock = KEY_NONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      unlock <= KEY_NONE;
    end else begin
      unlock <= next_unlock;
    end
  end

  // ==================================================
  // Control register; allow and op_select cleared by power-on reset only, idle_off by either reset
  wire [7:0] words_m1 = (cmd.op == OP_ROW) ? 8'(ROW_WORDS - 1) :
                        (cmd.op == OP_DWORD) ? 8'(DWORD_WORDS - 1) : 8'h00;
  wire last_word = word == words_m1;
  wire op_done = (seq == SEQ_PROG) & flash_done_i & last_word;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      launch <= CONTROL_RESET[BIT_LAUNCH];
      allow <= CONTROL_RESET[BIT_ALLOW];
      fault <= CONTROL_RESET[BIT_FAULT];
      op_select <= CONTROL_RESET[OPSEL_LSB +: OPSEL_W];
    end else begin
      if (ctl_hi_we) begin
        allow <= wb_dat_i[BIT_ALLOW];
      end
      if (ctl_lo_we) begin
        op_select <= wb_dat_i[OPSEL_LSB +: OPSEL_W];
      end
      if (launch_ok) begin
        launch <= 1'b1;
      end else if (op_done || abort) begin
        launch <= 1'b0;
      end
      if (launch_bad || abort) begin
        fault <= 1'b1;
      end else if (launch_ok) begin
        fault <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      idle_off <= CONTROL_RESET[BIT_IDLE_OFF];
      pwr_off <= 1'b0;
      pwr_standby <= 1'b0;
    end else begin
      if (ctl_hi_we) begin
        idle_off <= wb_dat_i[BIT_IDLE_OFF];
      end
      pwr_off <= idle_i & idle_off;
      pwr_standby <= idle_i & ~idle_off;
    end
  end

  // ==================================================
  // Destination and table registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dest_upper <= 8'h00;
      dest_lower <= 16'h0000;
      table_page <= TABLE_PAGE_RESET;
      latch_idx <= '0;
    end else begin
      if (bus_write && hit_upper && wb_sel_i[0]) begin
        dest_upper <= wb_dat_i[7:0];
      end
      if (bus_write && hit_lower && wb_sel_i[0]) begin
        dest_lower[7:0] <= wb_dat_i[7:0];
      end
      if (bus_write && hit_lower && wb_sel_i[1]) begin
        dest_lower[15:8] <= wb_dat_i[15:8];
      end
      if (bus_write && hit_page && wb_sel_i[0]) begin
        table_page <= wb_dat_i[7:0];
      end
      if (bus_write && hit_idx && wb_sel_i[0]) begin
        latch_idx <= wb_dat_i[LATCH_IDX_W-1:0];
      end else if (latch_we) begin
        latch_idx <= latch_idx + 1'b1;
      end
    end
  end

  // ==================================================
  // Holding latches
  wire [23:0] dest_addr = {dest_upper, dest_lower};
  wire [LATCH_IDX_W-1:0] rd_idx = (op_select == OP_DWORD) ?
                                  dest_lower[LATCH_IDX_W:1] + word[LATCH_IDX_W-1:0] :
                                  word[LATCH_IDX_W-1:0];

  write_latches #(
    .DEPTH(ROW_WORDS),
    .IDX_W(LATCH_IDX_W),
    .LANES(3)
  ) u_latches (
    .clk_i(clk_i),
    .we_i(latch_we),
    .be_i(wb_sel_i[2:0]),
    .widx_i(latch_idx),
    .wdata_i(wb_dat_i[LATCH_W-1:0]),
    .ridx_i(rd_idx),
    .rdata_o(latch_rdata)
  );

  // ==================================================
  // Sequencer, one request per word to the array for OP_DWORD and OP_ROW, a single request for OP_PAGE and OP_CHIP
  wire [23:0] base_addr = (op_select == OP_CHIP) ? CHIP_BASE :
                          (op_select == OP_PAGE) ? (dest_addr & PAGE_MASK) :
                          (op_select == OP_ROW) ? (dest_addr & ROW_MASK) : dest_addr;
  wire [23:0] word_addr = base_addr + {15'h0000, word, 1'b0};

  always_comb begin
    next_seq = seq;
    case (seq)
      SEQ_IDLE: begin
        if (launch_ok) begin
          next_seq = SEQ_LOAD;
        end
      end
      SEQ_LOAD: begin
        next_seq = SEQ_PROG;
      end
      SEQ_PROG: begin
        if (flash_done_i) begin
          next_seq = last_word ? SEQ_IDLE : SEQ_LOAD;
        end
      end
      default: begin
        next_seq = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      seq <= SEQ_IDLE;
      word <= 8'h00;
      cmd <= '0;
    end else begin
      seq <= next_seq;
      if (seq == SEQ_IDLE) begin
        word <= 8'h00;
      end else if (seq == SEQ_PROG && flash_done_i && !last_word) begin
        word <= word + 8'h01;
      end
      if (seq == SEQ_LOAD) begin
        cmd.op <= op_select;
        cmd.addr <= word_addr;
        cmd.data <= latch_rdata;
      end
    end
  end

  // Request held until the array reports the word done
  assign flash_req_o = seq == SEQ_PROG;
  assign flash_cmd_o = cmd;
  assign cpu_stall_o = launch;
  assign mem_power_off_o = pwr_off;
  assign mem_standby_o = pwr_standby;

  // ==================================================
  // Bus read and acknowledge
  wire [15:0] ctl_view = {launch, allow, fault, idle_off, 2'h0, 6'h00, op_select};
  wire [31:0] rd_mux = hit_ctl ? {16'h0000, ctl_view} :
                       hit_lower ? {16'h0000, dest_lower} :
                       hit_upper ? {24'h00_0000, dest_upper} :
                       hit_page ? {24'h00_0000, table_page} :
                       hit_idx ? {25'h000_0000, latch_idx} :
                       hit_status ? {28'h000_0000, pwr_standby, pwr_off, unlock == KEY_OPEN, seq != SEQ_IDLE} :
                       32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      ack <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      ack <= bus_req;
      if (bus_req && !wb_we_i) begin
        rd_data <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;

  // ==================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_start_needs_key: assert property ($rose(launch) |-> $past(unlock) == KEY_OPEN)
    else $error("launch without unlock");
  chk_key_reads_zero: assert property (ack && $past(hit_key && !wb_we_i) |-> wb_dat_o == 32'h0000_0000)
    else $error("key register read not zero");
  chk_launch_clears: assert property (op_done && !sys_rst_i |=> !launch && seq == SEQ_IDLE)
    else $error("launch not cleared at end");
  chk_stall_busy: assert property (flash_req_o |-> cpu_stall_o)
    else $error("array busy without stall");
  chk_allow_gate: assert property ($rose(launch) |-> allow)
    else $error("started while inhibited");
  chk_fault_bad: assert property (launch_bad && !launch |=> fault && !launch)
    else $error("bad launch not flagged");
  chk_idle_power: assert property (idle_i && idle_off && !sys_rst_i |=> mem_power_off_o && !mem_standby_o)
    else $error("idle power state wrong");
  chk_chip_fixed: assert property (flash_req_o && flash_cmd_o.op == OP_CHIP |-> flash_cmd_o.addr == CHIP_BASE)
    else $error("chip erase used destination");
  chk_valid_op: assert property (flash_req_o |-> flash_cmd_o.op != OP_UNUSED && flash_cmd_o.op != 4'h0)
    else $error("undefined operation issued");
  chk_ctl_reserved: assert property (ack && $past(hit_ctl && !wb_we_i) |-> wb_dat_o[11:4] == 8'h00)
    else $error("reserved bits read nonzero");
  chk_dword_addr: assert property (flash_req_o && flash_cmd_o.op == OP_DWORD && word == 8'h00
    |-> flash_cmd_o.addr == dest_addr)
    else $error("double word address wrong");
  chk_row_align: assert property (flash_req_o && flash_cmd_o.op == OP_ROW |-> flash_cmd_o.addr[7:0] == {word[6:0], 1'b0})
    else $error("row address misaligned");
  chk_key_cancel: assert property (unlock == KEY_HALF && bus_write && !key_second && !key_first |=> unlock == KEY_NONE)
    else $error("partial unlock not cancelled");
  chk_sysrst_keeps: assert property (sys_rst_i && !launch |=> allow == $past(allow) && op_select == $past(op_select))
    else $error("control lost on system reset");

  cov_row_done: cover property (op_done && cmd.op == OP_ROW);
  cov_chip_erase: cover property (flash_req_o && flash_cmd_o.op == OP_CHIP);
  cov_bad_launch: cover property (launch_bad);
  cov_dword_done: cover property (op_done && cmd.op == OP_DWORD);
endmodule : flash_program_erase_ctrl

/* File: src/write_latches.sv */
`timescale 1ns/1ps
module write_latches #(
  parameter int DEPTH = 128,
  parameter int IDX_W = 7,
  parameter int LANES = 3
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [LANES-1:0] be_i,
  input wire logic [IDX_W-1:0] widx_i,
  input wire logic [8*LANES-1:0] wdata_i,
  input wire logic [IDX_W-1:0] ridx_i,
  output logic [8*LANES-1:0] rdata_o
);
  // ==================================================
  // Holding latches, no reset: contents unknown after power-up
  logic [8*LANES-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < LANES; i++) begin
      if (we_i && be_i[i]) begin
        mem[widx_i][8*i +: 8] <= wdata_i[8*i +: 8];
      end
    end
  end

  assign rdata_o = mem[ridx_i];
endmodule : write_latches

/* File: tb/flash_array_model.sv */
`timescale 1ns/1ps
// ==================================================
// Array stand-in: answers each word after lat_i cycles
module flash_array_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic req_i,
  input wire flash_ctrl_pkg::flash_cmd_t cmd_i,
  input wire logic [3:0] lat_i,
  output logic done_o,
  output int count_o,
  output logic [23:0] sum_o,
  output flash_ctrl_pkg::flash_cmd_t first_o,
  output flash_ctrl_pkg::flash_cmd_t last_o
);
  import flash_ctrl_pkg::*;
  int wait_n = 0;
  logic spent = 1'b0;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (clr_i) begin
      count_o <= 0;
      sum_o <= 24'h00_0000;
    end else if (!req_i) begin
      wait_n <= 0;
      spent <= 1'b0;
    end else if (!spent && wait_n >= int'(lat_i)) begin
      // One pulse per word; req still looks high for a cycle after it
      done_o <= 1'b1;
      spent <= 1'b1;
      count_o <= count_o + 1;
      sum_o <= sum_o ^ cmd_i.addr ^ cmd_i.data;
      last_o <= cmd_i;
      if (count_o == 0) first_o <= cmd_i;
    end else if (!spent) begin
      wait_n <= wait_n + 1;
    end
  end
endmodule : flash_array_model

/* File: tb/flash_program_erase_ctrl_bench.sv */
`timescale 1ns/1ps
module flash_program_erase_ctrl_bench;
  import flash_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sys_rst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, clr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, lat = 4'h0, op;
  logic [31:0] dat = 32'h0000_0000, rd, r, dat_o;
  logic ack, stall, poff, stby, req, done;
  logic [23:0] dest, sum;
  logic [23:0] lat_mem [128];
  flash_cmd_t cmd, first, last;
  int count, n_mismatch = 0, check_count = 0, cycles = 0, seed = 57793;

  flash_program_erase_ctrl uut (.clk_i(clk), .rst_i(rst), .sys_rst_i(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .cpu_stall_o(stall), .idle_i(idle), .mem_power_off_o(poff), .mem_standby_o(stby), .flash_req_o(req),
    .flash_cmd_o(cmd), .flash_done_i(done));
  flash_array_model array (.clk_i(clk), .clr_i(clr), .req_i(req), .cmd_i(cmd), .lat_i(lat), .done_o(done),
    .count_o(count), .sum_o(sum), .first_o(first), .last_o(last));

  initial forever #5 clk = ~clk;
  // Whole run needs well under 10k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out;
    end
  end

  // ==================================================
  // Checks and bus cycles
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd = dat_o;
    if (ack !== 1'b1) chk_bit("bus ack", 1'b1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(a, 1'b0, 32'h0000_0000, 4'hf);
    chk(nm, 64'(e), 64'(rd));
  endtask : rd_chk
  task automatic wait_idle;
    int n;
    n = 0;
    while (stall !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_idle
  task automatic done_test(input string nm);
    $display("test %s finished", nm);
  endtask : done_test
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ==================================================
  // Expectations
  function automatic logic [23:0] op_base(input logic [3:0] o, input logic [23:0] d);
    return o == OP_PAGE ? d & PAGE_MASK : o == OP_ROW ? d & ROW_MASK : o == OP_CHIP ? CHIP_BASE : d;
  endfunction : op_base
  function automatic logic [23:0] row_sum(input logic [23:0] base);
    logic [23:0] x;
    x = 24'h00_0000;
    for (int k = 0; k < ROW_WORDS; k++) x = x ^ (base + 24'(2 * k)) ^ lat_mem[k];
    return x;
  endfunction : row_sum

  // Mode, address, keys, launch; keys 0 none, 1 proper, 2 split by another write
  task automatic start(input logic [3:0] o, input logic allow, input int keys, input int nreq, input logic ab);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[14] = allow;
    c[3:0] = o;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wb(OFS_CONTROL, 1'b1, c, 4'h3);
    wb(OFS_ADDR_LOWER, 1'b1, {16'h0000, dest[15:0]}, 4'h3);
    wb(OFS_ADDR_UPPER, 1'b1, {24'h00_0000, dest[23:16]}, 4'h1);
    if (keys > 0) wb(OFS_UNLOCK_KEY, 1'b1, {24'h00_0000, KEY_FIRST}, 4'h1);
    if (keys == 2) wb(OFS_ADDR_UPPER, 1'b1, {24'h00_0000, dest[23:16]}, 4'h1);
    if (keys > 0) wb(OFS_UNLOCK_KEY, 1'b1, {24'h00_0000, KEY_SECOND}, 4'h1);
    c[15] = 1'b1;
    wb(OFS_CONTROL, 1'b1, c, 4'h3);
    @(posedge clk);
    chk_bit("stall", nreq > 0, stall);
    if (ab) begin
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
    end
    wait_idle;
    c[15] = 1'b0;
    c[13] = (nreq == 0) || ab;
    rd_chk(OFS_CONTROL, c, "control after launch");
    if (!ab) chk("requests", 64'(nreq), 64'(count));
  endtask : start

  // ==================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CONTROL, 32'h0000_0000, "control reset");
    wb(OFS_UNLOCK_KEY, 1'b1, {24'h00_0000, KEY_FIRST}, 4'h1);
    rd_chk(OFS_UNLOCK_KEY, 32'h0000_0000, "key read");
    rd_chk(8'h20, 32'h0000_0000, "unmapped read");
    wb(OFS_CONTROL, 1'b1, 32'h0000_23ff, 4'h3);
    rd_chk(OFS_CONTROL, 32'h0000_000f, "control fields");
    done_test("reset and map");
    wb(OFS_TABLE_PAGE, 1'b1, 32'h0000_0000, 4'h1);
    wb(OFS_LATCH_INDEX, 1'b1, 32'h0000_0000, 4'h1);
    wb(OFS_LATCH_DATA, 1'b1, 32'h00ab_cdef, 4'h7);
    rd_chk(OFS_LATCH_INDEX, 32'h0000_0000, "index after refused latch write");
    wb(OFS_TABLE_PAGE, 1'b1, {24'h00_0000, LATCH_PAGE}, 4'h1);
    wb(OFS_LATCH_INDEX, 1'b1, 32'h0000_0000, 4'h1);
    for (int k = 0; k < ROW_WORDS; k++) begin
      r = $random(seed);
      lat_mem[k] = r[23:0];
      wb(OFS_LATCH_DATA, 1'b1, {8'h00, r[23:0]}, 4'h7);
    end
    done_test("latch fill");
    dest = 24'h01_2345;
    start(OP_PAGE, 1'b1, 0, 0, 1'b0);
    start(OP_PAGE, 1'b1, 2, 0, 1'b0);
    start(OP_PAGE, 1'b0, 1, 0, 1'b0);
    for (int o = 0; o < 16; o++) begin
      if (!(o inside {1, 2, 3, 14})) start(o[3:0], 1'b1, 1, 0, 1'b0);
    end
    done_test("refused launches");
    r = $random(seed);
    dest = r[23:0];
    lat <= r[27:24];
    start(OP_DWORD, 1'b1, 1, 2, 1'b0);
    chk("dword first", 64'({OP_DWORD, dest, lat_mem[dest[7:1]]}), 64'(first));
    chk("dword last", 64'(lat_mem[7'(dest[7:1] + 7'h01)]), 64'(last.data));
    r = $random(seed);
    dest = r[23:0];
    start(OP_ROW, 1'b1, 1, ROW_WORDS, 1'b0);
    chk("row sum", 64'(row_sum(dest & ROW_MASK)), 64'(sum));
    chk("row first", 64'(op_base(OP_ROW, dest)), 64'(first.addr));
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      dest = r[23:0];
      lat <= r[27:24];
      op = i % 3 == 0 ? OP_DWORD : i % 3 == 1 ? OP_PAGE : OP_CHIP;
      start(op, 1'b1, 1, op == OP_DWORD ? 2 : 1, 1'b0);
      chk("op first", 64'({op, op_base(op, dest)}), 64'({first.op, first.addr}));
    end
    done_test("operations");
    wb(OFS_CONTROL, 1'b1, 32'h0000_1000, 4'h3);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit("power off", 1'b1, poff);
    chk_bit("standby", 1'b0, stby);
    wb(OFS_CONTROL, 1'b1, 32'h0000_0000, 4'h3);
    repeat (3) @(posedge clk);
    chk_bit("standby", 1'b1, stby);
    idle <= 1'b0;
    done_test("idle power");
    wb(OFS_CONTROL, 1'b1, 32'h0000_4003, 4'h3);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(OFS_CONTROL, 32'h0000_4003, "control after system reset");
    lat <= 4'hf;
    start(OP_PAGE, 1'b1, 1, 1, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CONTROL, 32'h0000_0000, "control after power-on reset");
    done_test("resets");
    close_out;
  end
endmodule : flash_program_erase_ctrl_bench
